// ===== core/dbm_cfg.svh
// Purpose: Timing and layout constants of the DRAM bank controller
// Assumes: System clock of 250 MHz
// Notes: Times in ns as specified, cycle counts derived from them
`ifndef DBM_CFG_SVH
`define DBM_CFG_SVH

// ----------------------------------------
// Clock and time conversion
// ----------------------------------------
`define DBM_CLK_MHZ 250
// Least times round up to whole cycles
`define DBM_CYC_UP(ns) ((((ns) * `DBM_CLK_MHZ) + 999) / 1000)
// Longest times round down
`define DBM_CYC_DN(ns) (((ns) * `DBM_CLK_MHZ) / 1000)

// ----------------------------------------
// DRAM strobe timing, 80 ns class parts
// ----------------------------------------
`define DBM_T_ASR_NS 10
`define DBM_T_RCD_NS 20
`define DBM_T_ASC_NS 10
`define DBM_T_CAS_NS 20
`define DBM_T_CP_NS 10
`define DBM_T_RP_NS 60
`define DBM_T_CSR_NS 10
`define DBM_T_RFRAS_NS 80
`define DBM_T_REF_NS 15600
`define DBM_ASR_CYC `DBM_CYC_UP(`DBM_T_ASR_NS)
`define DBM_RCD_CYC `DBM_CYC_UP(`DBM_T_RCD_NS)
`define DBM_ASC_CYC `DBM_CYC_UP(`DBM_T_ASC_NS)
`define DBM_CAS_CYC `DBM_CYC_UP(`DBM_T_CAS_NS)
`define DBM_CP_CYC `DBM_CYC_UP(`DBM_T_CP_NS)
`define DBM_RP_CYC `DBM_CYC_UP(`DBM_T_RP_NS)
`define DBM_CSR_CYC `DBM_CYC_UP(`DBM_T_CSR_NS)
`define DBM_RFRAS_CYC `DBM_CYC_UP(`DBM_T_RFRAS_NS)
`define DBM_REF_CYC `DBM_CYC_DN(`DBM_T_REF_NS)
// Read data passes a two-stage pin synchroniser
`define DBM_SYNC_CYC 2

// ----------------------------------------
// Banks, sizes, bursts
// ----------------------------------------
`define DBM_BANKS 4
`define DBM_BURST_LAST 2'h3
`define DBM_SZ_NONE 2'h0
`define DBM_SZ_1MB 2'h1
`define DBM_SZ_4MB 2'h2
`define DBM_SZ_16MB 2'h3
`define DBM_LEN_1MB 26'h10_0000
`define DBM_LEN_4MB 26'h40_0000
`define DBM_LEN_16MB 26'h100_0000
`define DBM_ALL_HIGH 4'hf
`define DBM_ALL_LOW 4'h0
// Refresh period is cut by more than the longest access, a read burst of 72 cycles
`define DBM_REF_SLACK 96

`endif

// ===== core/dbm_pkg.sv
// Purpose: Types shared by the DRAM bank controller
// Assumes: Nothing beyond SystemVerilog
// Notes: Constants live in dbm_cfg.svh
package dbm_pkg;
    typedef enum logic [3:0] {
        DBM_IDLE, DBM_ROW, DBM_RAS, DBM_COL, DBM_CAS, DBM_CPRE, DBM_PRE,
        DBM_RF_CAS, DBM_RF_RAS
    } dbm_state_t;

    typedef struct packed {
        logic hit;
        logic [1:0] idx;
        logic [25:0] off;
    } dbm_hit_t;
endpackage

// ===== core/dbm_ref_timer.sv
// Purpose: Interval timer that asks for one refresh per period
// Assumes: Single clock, asynchronous active-low reset
// Notes: A new tick in the cycle of the acknowledge keeps the request
`timescale 1ns/1ps
`include "dbm_cfg.svh"
module dbm_ref_timer (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Refresh handshake
    input wire logic ref_ack,
    output logic ref_pend
);
    import dbm_pkg::*;

    logic [11:0] cnt_q, cnt_d;
    logic pend_q, pend_d;
    logic tick;

    always_comb begin
        tick = (cnt_q == 12'h000);
        // Short period, so a refresh held back by a burst still lands in time
        cnt_d = tick ? 12'(`DBM_REF_CYC - `DBM_REF_SLACK - 1) : cnt_q - 12'h001;
        // Set wins over clear
        pend_d = tick | (pend_q & ~ref_ack);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= 12'(`DBM_REF_CYC - `DBM_REF_SLACK - 1);
            pend_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            pend_q <= pend_d;
        end
    end

    assign ref_pend = pend_q;
endmodule

// ===== core/dbm_ctrl.sv
// Purpose: Four-bank page-mode DRAM controller with address mux and refresh
// Assumes: Host on the same 250 MHz clock; DRAM data pins are asynchronous
// Notes: One access at a time; bank modes and sizes are static inputs
// Overview of operation
// - Serves 1, 4 and 16 Mbit parts
// - Four banks, own row strobe, own mode
// - Decodes 1/2/4/8/16/32 MB populations
// - CAS-before-RAS refresh within 15.6 us
// - Line bursts, no interleave across banks
// - 12-bit bus, row then column
// - Two mux modes, chosen per bank
// - Software sets modes during memory sizing
// - Mode 1 row bit map
// - Mode 1 column bit map
// - Mode 0 row bit map
// - Mode 0 column bit map
`timescale 1ns/1ps
`include "dbm_cfg.svh"
module dbm_ctrl (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Bank setup written by software
    input wire logic [3:0] bank_mode,
    input wire logic [7:0] bank_size,
    // Request
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [25:0] req_addr,
    input wire logic req_write,
    input wire logic req_burst,
    input wire logic [3:0] req_be,
    input wire logic [31:0] wr_data,
    // Answer
    output logic beat_ack,
    output logic [31:0] rd_data,
    output logic req_err,
    output dbm_pkg::dbm_state_t state,
    // DRAM pins
    output logic [11:0] dram_addr,
    output logic [3:0] ras_n,
    output logic [3:0] cas_n,
    output logic we_n,
    output logic [31:0] dq_out,
    output logic dq_oe,
    input wire logic [31:0] dq_in
);
    import dbm_pkg::*;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Mode bit picks the map, col picks the phase
    function automatic logic [11:0] mux_addr(input logic mode, input logic col,
                                             input logic [25:0] a);
        logic [11:0] r;
        unique case ({mode, col})
            2'b10: r = {a[23], a[22], a[20:11]};
            2'b11: r = {a[24], a[23], a[21], a[10:2]};
            2'b00: r = {a[21], a[20], a[10], a[19:11]};
            2'b01: r = {a[24], a[23], a[25], a[22], a[9:2]};
        endcase
        return r;
    endfunction

    function automatic logic [25:0] size_of(input logic [1:0] code);
        logic [25:0] r;
        unique case (code)
            `DBM_SZ_NONE: r = '0;
            `DBM_SZ_1MB: r = `DBM_LEN_1MB;
            `DBM_SZ_4MB: r = `DBM_LEN_4MB;
            `DBM_SZ_16MB: r = `DBM_LEN_16MB;
        endcase
        return r;
    endfunction

    // Banks are stacked in order from address zero, empty banks take no space
    function automatic dbm_hit_t bank_find(input logic [25:0] a, input logic [7:0] sz);
        dbm_hit_t r;
        logic [26:0] base;
        logic [26:0] len;
        r = '0;
        base = '0;
        for (int i = 0; i < `DBM_BANKS; i++) begin
            len = {1'b0, size_of(sz[2*i +: 2])};
            if (!r.hit && len != '0 && {1'b0, a} >= base && {1'b0, a} < base + len) begin
                r.hit = 1'b1;
                r.idx = 2'(i);
                r.off = 26'({1'b0, a} - base);
            end
            base = base + len;
        end
        return r;
    endfunction

    function automatic logic [4:0] wait_of(input int n);
        return 5'(n - 1);
    endfunction

    // ----------------------------------------
    // Read data synchroniser
    // ----------------------------------------
    logic [31:0] dq_s1_q, dq_s2_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dq_s1_q <= '0;
            dq_s2_q <= '0;
        end else begin
            dq_s1_q <= dq_in;
            dq_s2_q <= dq_s1_q;
        end
    end

    // ----------------------------------------
    // Refresh request
    // ----------------------------------------
    logic ref_pend, ref_ack;

    dbm_ref_timer u_ref (
        .clk(clk),
        .resetn(resetn),
        .ref_ack(ref_ack),
        .ref_pend(ref_pend)
    );

    // ----------------------------------------
    // Access sequencer
    // ----------------------------------------
    dbm_state_t st_q, st_d;
    logic [4:0] cnt_q, cnt_d;
    logic [25:0] off_q, off_d;
    logic [1:0] bank_q, bank_d;
    logic [1:0] beat_q, beat_d;
    logic wr_q, wr_d, burst_q, burst_d;
    logic [3:0] be_q, be_d;
    logic [11:0] addr_q, addr_d;
    logic [3:0] ras_q, ras_d, cas_q, cas_d;
    logic we_q, we_d, oe_q, oe_d, ack_q, ack_d, err_q, err_d;
    logic [31:0] dout_q, dout_d, rd_q, rd_d;
    dbm_hit_t hit;
    logic mode_sel;
    logic [25:0] col_off;

    always_comb begin
        hit = bank_find(req_addr, bank_size);
        mode_sel = bank_mode[bank_q];
        // Line burst walks the word index within the line, wrapping
        col_off = {off_q[25:4], beat_q, off_q[1:0]};
        st_d = st_q;
        cnt_d = (cnt_q != 5'h00) ? cnt_q - 5'h01 : cnt_q;
        off_d = off_q;
        bank_d = bank_q;
        beat_d = beat_q;
        wr_d = wr_q;
        burst_d = burst_q;
        be_d = be_q;
        addr_d = addr_q;
        ras_d = ras_q;
        cas_d = cas_q;
        we_d = we_q;
        oe_d = oe_q;
        dout_d = dout_q;
        rd_d = rd_q;
        ack_d = 1'b0;
        err_d = 1'b0;
        ref_ack = 1'b0;
        unique case (st_q)
            DBM_IDLE: begin
                if (ref_pend) begin
                    // CAS first on every bank selects CBR refresh
                    cas_d = `DBM_ALL_LOW;
                    cnt_d = wait_of(`DBM_CSR_CYC);
                    st_d = DBM_RF_CAS;
                end else if (req_valid && !hit.hit) begin
                    err_d = 1'b1;
                end else if (req_valid) begin
                    off_d = hit.off;
                    bank_d = hit.idx;
                    beat_d = hit.off[3:2];
                    wr_d = req_write;
                    burst_d = req_burst;
                    be_d = req_be;
                    // Row goes out first, strobe follows after setup
                    addr_d = mux_addr(bank_mode[hit.idx], 1'b0, hit.off);
                    cnt_d = wait_of(`DBM_ASR_CYC);
                    st_d = DBM_ROW;
                end
            end
            DBM_ROW: begin
                if (cnt_q == 5'h00) begin
                    ras_d[bank_q] = 1'b0;
                    cnt_d = wait_of(`DBM_RCD_CYC);
                    st_d = DBM_RAS;
                end
            end
            DBM_RAS: begin
                if (cnt_q == 5'h00) begin
                    addr_d = mux_addr(mode_sel, 1'b1, col_off);
                    cnt_d = wait_of(`DBM_ASC_CYC);
                    st_d = DBM_COL;
                end
            end
            DBM_COL: begin
                if (cnt_q == 5'h00) begin
                    // Writes strobe only the enabled byte lanes
                    cas_d = wr_q ? ~be_q : `DBM_ALL_LOW;
                    we_d = ~wr_q;
                    oe_d = wr_q;
                    dout_d = wr_data;
                    cnt_d = wr_q ? wait_of(`DBM_CAS_CYC)
                                 : wait_of(`DBM_CAS_CYC + `DBM_SYNC_CYC);
                    st_d = DBM_CAS;
                end
            end
            DBM_CAS: begin
                if (cnt_q == 5'h00) begin
                    cas_d = `DBM_ALL_HIGH;
                    ack_d = 1'b1;
                    if (!wr_q) begin
                        rd_d = dq_s2_q;
                    end
                    // Page mode: RAS stays on one bank for the whole line
                    if (burst_q && (beat_q + 2'h1) != off_q[3:2]) begin
                        beat_d = beat_q + 2'h1;
                        cnt_d = wait_of(`DBM_CP_CYC);
                        st_d = DBM_CPRE;
                    end else begin
                        ras_d = `DBM_ALL_HIGH;
                        we_d = 1'b1;
                        oe_d = 1'b0;
                        cnt_d = wait_of(`DBM_RP_CYC);
                        st_d = DBM_PRE;
                    end
                end
            end
            DBM_CPRE: begin
                if (cnt_q == 5'h00) begin
                    addr_d = mux_addr(mode_sel, 1'b1, col_off);
                    cnt_d = wait_of(`DBM_ASC_CYC);
                    st_d = DBM_COL;
                end
            end
            DBM_PRE: begin
                if (cnt_q == 5'h00) begin
                    st_d = DBM_IDLE;
                end
            end
            DBM_RF_CAS: begin
                if (cnt_q == 5'h00) begin
                    ras_d = `DBM_ALL_LOW;
                    ref_ack = 1'b1;
                    cnt_d = wait_of(`DBM_RFRAS_CYC);
                    st_d = DBM_RF_RAS;
                end
            end
            DBM_RF_RAS: begin
                if (cnt_q == 5'h00) begin
                    ras_d = `DBM_ALL_HIGH;
                    cas_d = `DBM_ALL_HIGH;
                    cnt_d = wait_of(`DBM_RP_CYC);
                    st_d = DBM_PRE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= DBM_IDLE;
            cnt_q <= '0;
            off_q <= '0;
            bank_q <= '0;
            beat_q <= '0;
            wr_q <= 1'b0;
            burst_q <= 1'b0;
            be_q <= '0;
            addr_q <= '0;
            ras_q <= `DBM_ALL_HIGH;
            cas_q <= `DBM_ALL_HIGH;
            we_q <= 1'b1;
            oe_q <= 1'b0;
            dout_q <= '0;
            rd_q <= '0;
            ack_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            off_q <= off_d;
            bank_q <= bank_d;
            beat_q <= beat_d;
            wr_q <= wr_d;
            burst_q <= burst_d;
            be_q <= be_d;
            addr_q <= addr_d;
            ras_q <= ras_d;
            cas_q <= cas_d;
            we_q <= we_d;
            oe_q <= oe_d;
            dout_q <= dout_d;
            rd_q <= rd_d;
            ack_q <= ack_d;
            err_q <= err_d;
        end
    end

    // Refresh outranks a waiting request, so ready drops while one is due
    assign req_ready = (st_q == DBM_IDLE) && !ref_pend;
    assign beat_ack = ack_q;
    assign rd_data = rd_q;
    assign req_err = err_q;
    assign state = st_q;
    assign dram_addr = addr_q;
    assign ras_n = ras_q;
    assign cas_n = cas_q;
    assign we_n = we_q;
    assign dq_out = dout_q;
    assign dq_oe = oe_q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    logic [12:0] since_ref_q;
    logic in_ref;

    assign in_ref = (st_q == DBM_RF_CAS) || (st_q == DBM_RF_RAS);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            since_ref_q <= '0;
        end else begin
            since_ref_q <= (st_q == DBM_RF_CAS) ? 13'h0000 : since_ref_q + 13'h0001;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_ras_single;
        !in_ref && st_q != DBM_PRE |-> $countones(~ras_q) <= 1;
    endproperty
    a_ras_single: assert property (p_ras_single) else $error("two banks open");

    property p_row_first;
        ($fell(ras_q[bank_q]) && !in_ref) |->
            addr_q == mux_addr(bank_mode[bank_q], 1'b0, off_q) && $stable(addr_q);
    endproperty
    a_row_first: assert property (p_row_first) else $error("row not set up");

    property p_col_first;
        ($fell(&cas_q) || ($fell(|cas_q) && !in_ref && st_q == DBM_CAS)) && !in_ref |->
            addr_q == mux_addr(mode_sel, 1'b1, col_off) && !ras_q[bank_q];
    endproperty
    a_col_first: assert property (p_col_first) else $error("column not set up");

    property p_cbr;
        // Only a refresh drops every row strobe at once
        $fell(|ras_q) |-> $past(cas_q) == `DBM_ALL_LOW && in_ref;
    endproperty
    a_cbr: assert property (p_cbr) else $error("refresh without cas first");

    property p_ref_interval;
        since_ref_q <= 13'(`DBM_REF_CYC);
    endproperty
    a_ref_interval: assert property (p_ref_interval) else $error("refresh late");

    property p_no_interleave;
        (st_q == DBM_CPRE) |=> $stable(ras_q);
    endproperty
    a_no_interleave: assert property (p_no_interleave) else $error("bank changed");

    property p_unmapped;
        req_valid && req_ready && !hit.hit |=> req_err && st_q == DBM_IDLE;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");

    property p_mode_row;
        req_valid && req_ready && hit.hit |=>
            addr_q == mux_addr($past(bank_mode[hit.idx]), 1'b0, $past(hit.off));
    endproperty
    a_mode_row: assert property (p_mode_row) else $error("wrong row map");

    property p_ack_pulse;
        beat_ack |=> !beat_ack ##0 (&cas_q);
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack not a pulse");

    c_refresh: cover property (st_q == DBM_RF_CAS ##1 st_q == DBM_RF_CAS);
    c_err: cover property (req_err);
    c_burst: cover property (beat_ack && burst_q && !wr_q ##[1:40] beat_ack);
    c_write: cover property (beat_ack && wr_q);
endmodule

// ===== sim/dbm_dram_model.sv
// Purpose: Behavioural page-mode DRAM bank set seen from the controller pins
// Assumes: Strobes change only just after the rising clock edge
// Notes: Unwritten cells read a pattern made from their location
`timescale 1ns/1ps
module dbm_dram_model (
    // Clock and pacing
    input wire logic clk,
    input wire logic slow,
    // DRAM pins
    input wire logic [11:0] dram_addr,
    input wire logic [3:0] ras_n,
    input wire logic [3:0] cas_n,
    input wire logic we_n,
    input wire logic [31:0] dq_out,
    input wire logic dq_oe,
    output logic [31:0] dq_in,
    // Observation
    output logic [1:0] last_bank,
    output logic [11:0] last_row,
    output logic [11:0] last_col,
    output int n_acc,
    output int n_ref,
    output int last_gap
);
    logic [31:0] mem [logic [25:0]];
    logic [11:0] row_q [4];
    logic [3:0] ras_p = 4'hf;
    logic [3:0] cas_p = 4'hf;
    logic [31:0] rd_word = 32'h0000_0000;
    logic [31:0] last_word = 32'h0000_0000;
    logic [25:0] key;
    logic rd_on = 1'b0;
    int wait_q = 0;
    int since = 0;

    // ----------------------------------------
    // Strobe decoding
    // ----------------------------------------
    always @(posedge clk) begin
        since = since + 1;
        if (wait_q > 0)
            wait_q = wait_q - 1;
        for (int b = 0; b < 4; b++) begin
            if (ras_p[b] && !ras_n[b])
                row_q[b] = dram_addr;
        end
        // Column strobe already low when a row strobe falls marks a refresh
        if ((ras_p & ~ras_n) != 4'h0 && cas_p != 4'hf) begin
            if (n_ref > 0)
                last_gap = since;
            since = 0;
            n_ref = n_ref + 1;
        end
        if (cas_p == 4'hf && cas_n != 4'hf && ras_n != 4'hf) begin
            for (int b = 0; b < 4; b++) begin
                if (!ras_n[b])
                    last_bank = 2'(b);
            end
            last_row = row_q[last_bank];
            last_col = dram_addr;
            key = {last_bank, last_row, last_col};
            n_acc = n_acc + 1;
            rd_word = mem.exists(key) ? mem[key] : {6'h2a, key};
            if (!we_n) begin
                for (int l = 0; l < 4; l++) begin
                    if (!cas_n[l])
                        rd_word[8*l+:8] = dq_out[8*l+:8];
                end
                mem[key] = rd_word;
            end else begin
                rd_on = 1'b1;
                wait_q = slow ? 2 : 0;
            end
        end
        if (cas_n == 4'hf && rd_on) begin
            rd_on = 1'b0;
            last_word = rd_word;
        end
        ras_p = ras_n;
        cas_p = cas_n;
    end

    // A released bus shows the inverse of its last value, never a stale copy
    assign dq_in = dq_oe ? dq_out : ((rd_on && wait_q == 0) ? rd_word : ~last_word);
endmodule

// ===== sim/test_dbm_ctrl.sv
// Purpose: Self-checking bench of the four-bank DRAM controller
// Assumes: Inputs change on the falling clock edge
// Notes: Banks of 16, 16, 4 and 1 MB stacked from address zero
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_errors++; \
    $display("ERROR t=%0t got 0x%h exp 0x%h", $time, (got), (exp)); end end
module test_dbm_ctrl;
    import dbm_pkg::*;
    typedef struct packed {logic [25:0] addr; logic [1:0] bank;} dbm_row_t;
    localparam int REF_LIMIT = 15600 / 4;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] bank_mode = 4'h5;
    // Two-module layout: one two-bank 32 MB module, then 4 MB and 1 MB banks
    logic [7:0] bank_size = 8'h6f;
    logic req_valid = 1'b0;
    logic [25:0] req_addr = 26'h000_0000;
    logic req_write = 1'b0;
    logic req_burst = 1'b0;
    logic [3:0] req_be = 4'hf;
    logic [31:0] wr_data = 32'h0000_0000;
    logic slow = 1'b0;
    logic req_ready, beat_ack, req_err, we_n, dq_oe;
    logic [31:0] rd_data, dq_out, dq_in;
    logic [11:0] dram_addr, last_row, last_col;
    logic [3:0] ras_n, cas_n;
    logic [1:0] last_bank;
    dbm_state_t state;
    int n_acc, n_ref, last_gap;
    int n_errors = 0;
    int checks_done = 0;
    logic [25:0] base_of [4] = '{26'h000_0000, 26'h100_0000, 26'h200_0000, 26'h240_0000};
    dbm_row_t rows [7] = '{'{26'h000_0004, 2'h0}, '{26'h0ff_fffc, 2'h0},
        '{26'h100_0000, 2'h1}, '{26'h1a5_a5a8, 2'h1}, '{26'h23f_fffc, 2'h2},
        '{26'h240_0000, 2'h3}, '{26'h24f_fff0, 2'h3}};

    always #2 clk = ~clk;

    dbm_ctrl i_dut (.clk(clk), .resetn(resetn), .bank_mode(bank_mode),
        .bank_size(bank_size), .req_valid(req_valid), .req_ready(req_ready),
        .req_addr(req_addr), .req_write(req_write), .req_burst(req_burst),
        .req_be(req_be), .wr_data(wr_data), .beat_ack(beat_ack), .rd_data(rd_data),
        .req_err(req_err), .state(state), .dram_addr(dram_addr), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));

    dbm_dram_model i_dram (.clk(clk), .slow(slow), .dram_addr(dram_addr), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in),
        .last_bank(last_bank), .last_row(last_row), .last_col(last_col),
        .n_acc(n_acc), .n_ref(n_ref), .last_gap(last_gap));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Row in [23:12], column in [11:0], from the offset inside the bank
    function automatic logic [23:0] mux_of(input logic mode, input logic [25:0] a);
        if (mode)
            return {a[23], a[22], a[20], a[19:11], a[24], a[23], a[21], a[10:2]};
        return {a[21], a[20], a[10], a[19:11], a[24], a[23], a[25], a[22], a[9:2]};
    endfunction

    task automatic access(input logic [25:0] a, input logic wr, input logic bu,
                          input logic [3:0] be, input logic [127:0] wd,
                          output logic [127:0] rd, output logic err);
        int n;
        int k;
        n = bu ? 4 : 1;
        k = 0;
        err = 1'b0;
        rd = '0;
        for (int t = 0; t < 300 && req_ready !== 1'b1; t++)
            @(negedge clk);
        req_valid = 1'b1;
        req_addr = a;
        req_write = wr;
        req_burst = bu;
        req_be = be;
        wr_data = wd[31:0];
        for (int t = 0; t < 300 && k < n && !err; t++) begin
            @(negedge clk);
            req_valid = 1'b0;
            if (req_err === 1'b1)
                err = 1'b1;
            if (beat_ack === 1'b1) begin
                rd[32*k+:32] = rd_data;
                k++;
                if (k < n)
                    wr_data = wd[32*k+:32];
            end
        end
        `CHK(err || k == n, 1'b1)
    endtask

    task automatic complete_run();
        if (n_errors == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (40000) @(posedge clk);
        n_errors++;
        complete_run();
    end

    initial begin
        logic [127:0] rd;
        logic err;
        logic [23:0] exp_rc;
        logic [31:0] dat;
        int ref0;
        int acc0;
        repeat (16) @(negedge clk);
        `CHK({ras_n, cas_n, we_n, dq_oe, req_ready}, 11'h7fd)
        resetn = 1'b1;
        // Square parts on banks 0 and 2 first, then software swaps the modes
        for (int ph = 0; ph < 2; ph++) begin
            bank_mode = ph ? 4'ha : 4'h5;
            slow = ph[0];
            for (int i = 0; i < 7; i++) begin
                dat = {rows[i].addr[15:0], 14'(i), ph[1:0]};
                access(rows[i].addr, 1'b1, 1'b0, 4'hf, {96'h0, dat}, rd, err);
                access(rows[i].addr, 1'b0, 1'b0, 4'hf, 128'h0, rd, err);
                exp_rc = mux_of(bank_mode[rows[i].bank], rows[i].addr - base_of[rows[i].bank]);
                `CHK(rd[31:0], dat)
                `CHK(last_bank, rows[i].bank)
                `CHK(last_row, exp_rc[23:12])
                `CHK(last_col, exp_rc[11:0])
            end
        end
        // First address past the populated space: refused without a DRAM cycle
        acc0 = n_acc;
        access(26'h250_0000, 1'b0, 1'b0, 4'hf, 128'h0, rd, err);
        `CHK({err, n_acc == acc0}, 2'h3)
        // An empty bank takes no space: bank 3 then follows bank 1 directly
        bank_size = 8'h4f;
        access(26'h200_0000, 1'b0, 1'b0, 4'hf, 128'h0, rd, err);
        `CHK({err, last_bank, last_row, last_col}, {1'b0, 2'h3, 24'h00_0000})
        `CHK(rd[31:0], 32'h0000_0015)
        access(26'h210_0000, 1'b0, 1'b0, 4'hf, 128'h0, rd, err);
        `CHK(err, 1'b1)
        bank_size = 8'h6f;
        access(26'h000_0100, 1'b1, 1'b0, 4'hf, {96'h0, 32'h1111_2222}, rd, err);
        access(26'h000_0100, 1'b1, 1'b0, 4'h5, {96'h0, 32'haaaa_bbbb}, rd, err);
        access(26'h000_0100, 1'b0, 1'b0, 4'hf, 128'h0, rd, err);
        `CHK(rd[31:0], 32'h11aa_22bb)
        // Bursts start mid-line and wrap
        access(26'h100_0208, 1'b1, 1'b1, 4'hf,
               128'h4444_4444_3333_3333_2222_2222_1111_1111, rd, err);
        access(26'h100_0204, 1'b0, 1'b1, 4'hf, 128'h0, rd, err);
        `CHK(rd, 128'h3333_3333_2222_2222_1111_1111_4444_4444)
        ref0 = n_ref;
        repeat (8000) @(negedge clk);
        `CHK(n_ref - ref0 >= 2, 1'b1)
        `CHK(last_gap > 0 && last_gap <= REF_LIMIT, 1'b1)
        // Reset with the row strobe of a burst open, before its first beat, must raise every strobe at once
        for (int t = 0; t < 300 && req_ready !== 1'b1; t++)
            @(negedge clk);
        req_valid = 1'b1;
        req_write = 1'b0;
        req_burst = 1'b1;
        req_addr = 26'h000_0100;
        @(negedge clk);
        req_valid = 1'b0;
        repeat (4) @(negedge clk);
        `CHK(ras_n, 4'he)
        resetn = 1'b0;
        #1;
        `CHK({ras_n, cas_n, we_n, dq_oe, beat_ack}, 11'h7fc)
        `CHK(state, DBM_IDLE)
        @(negedge clk);
        resetn = 1'b1;
        access(26'h000_0100, 1'b0, 1'b0, 4'hf, 128'h0, rd, err);
        `CHK(rd[31:0], 32'h11aa_22bb)
        complete_run();
    end
endmodule
